// ===== design/rcpoc_pkg.sv
// Package of constants and types for the reset cause and power-on-clear block
package rcpoc_pkg;

  localparam logic [15:0] RCPOC_CAUSE_OFFSET = 16'hffac;
  localparam logic [7:0]  RCPOC_CAUSE_RESET  = 8'h00;
  localparam int          RCPOC_WDT_BIT      = 4;
  localparam int          RCPOC_UV_BIT       = 0;
  localparam logic [7:0]  RCPOC_CAUSE_USED   = 8'h11;

  // Stabilization wait in hysteresis mode
  localparam int          RCPOC_STAB_US      = 5390;
  localparam int          RCPOC_CLK_MHZ      = 125;
  localparam int          RCPOC_STAB_CYC     = RCPOC_STAB_US * RCPOC_CLK_MHZ;
  localparam int          RCPOC_FAST_US      = 1930;
  localparam int          RCPOC_FAST_CYC     = RCPOC_FAST_US * RCPOC_CLK_MHZ;
  localparam int          RCPOC_CNT_W        = 20;
  localparam logic [RCPOC_CNT_W-1:0] RCPOC_CNT_ZERO = 20'h0_0000;

  typedef enum logic [1:0] {
    RCPOC_ST_HOLD = 2'b00,
    RCPOC_ST_RISE = 2'b01,
    RCPOC_ST_STAB = 2'b10,
    RCPOC_ST_RUN  = 2'b11
  } rcpoc_state_e;

  typedef struct packed {
    logic above_detect;
    logic above_release;
  } rcpoc_cmp_s;

  typedef struct packed {
    logic       rd;
    logic [15:0] addr;
  } rcpoc_bus_s;

endpackage : rcpoc_pkg

// ===== design/rcpoc_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module rcpoc_sync
  import rcpoc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  always_comb begin
    nxt_meta = din;
    nxt_sync = meta_ff;
    if (!rst_b) begin
      nxt_meta = '0;
      nxt_sync = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign dout = sync_ff;
endmodule : rcpoc_sync

// ===== design/rcpoc_poc_fsm.sv
// Power-on-clear sequencer: threshold mode selection and stabilization wait
`timescale 1ns/1ps
module rcpoc_poc_fsm
  import rcpoc_pkg::*;
#(
  parameter logic [RCPOC_CNT_W-1:0] STAB_CYC = RCPOC_CNT_W'(RCPOC_STAB_CYC),
  parameter logic [RCPOC_CNT_W-1:0] FAST_CYC = RCPOC_CNT_W'(RCPOC_FAST_CYC)
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       threshold_select,
  input  wire rcpoc_cmp_s cmp,
  output logic            poc_active
);
  rcpoc_state_e                state_ff;
  rcpoc_state_e                nxt_state;
  logic [RCPOC_CNT_W-1:0]      cnt_ff;
  logic [RCPOC_CNT_W-1:0]      nxt_cnt;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (!rst_b) begin
      nxt_state = RCPOC_ST_HOLD;
      nxt_cnt   = RCPOC_CNT_ZERO;
    end else if (!cmp.above_detect) begin
      nxt_state = RCPOC_ST_HOLD;
      nxt_cnt   = RCPOC_CNT_ZERO;
    end else begin
      unique case (state_ff)
        RCPOC_ST_HOLD: begin
          nxt_cnt = RCPOC_CNT_ZERO;
          if (!threshold_select) nxt_state = RCPOC_ST_RUN;
          else nxt_state = RCPOC_ST_RISE;
        end
        RCPOC_ST_RISE: begin
          if (cnt_ff != FAST_CYC) nxt_cnt = cnt_ff + 1'b1;
          if (cmp.above_release) begin
            // Fast rise gets the automatic stabilization wait
            nxt_state = (cnt_ff < FAST_CYC) ? RCPOC_ST_STAB : RCPOC_ST_RUN;
            nxt_cnt   = RCPOC_CNT_ZERO;
          end
        end
        RCPOC_ST_STAB: begin
          nxt_cnt = cnt_ff + 1'b1;
          if (cnt_ff >= STAB_CYC - 1'b1) nxt_state = RCPOC_ST_RUN;
        end
        RCPOC_ST_RUN: begin
          nxt_cnt = RCPOC_CNT_ZERO;
          // Dropping below release level alone does not reset in hysteresis mode
          if (!threshold_select) nxt_state = RCPOC_ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    state_ff <= nxt_state;
    cnt_ff   <= nxt_cnt;
  end

  assign poc_active = (state_ff != RCPOC_ST_RUN);
endmodule : rcpoc_poc_fsm

// ===== design/rcpoc_top.sv
// Reset cause register and power-on-clear reset generation
//
// Behaviour
// - Register records watchdog or undervoltage reset cause
// - Register read only as whole byte
// - Pin reset, power-on clear, read clear it
// - Watchdog request sets bit 4
// - Undervoltage request sets bit 0
// - Internal resets keep the other flag
// - Low mode releases above detect level
// - High mode releases above release level
// - Low mode follows detect comparator both ways
// - Hysteresis: assert low, release high
// - High mode fast rise adds stabilization wait
`timescale 1ns/1ps
module rcpoc_top
  import rcpoc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       ext_reset_pin_b,
  input  wire logic       watchdog_reset_req,
  input  wire logic       undervoltage_reset_req,
  input  wire logic       power_on_threshold_select,
  input  wire logic       supply_above_detect,
  input  wire logic       supply_above_release,
  input  wire logic       bus_rd,
  input  wire logic       bus_byte,
  input  wire logic [15:0] bus_addr,
  output logic      [7:0] bus_rdata,
  output logic            bus_rvalid,
  output logic            chip_reset_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  logic [4:0] raw_in;
  logic [4:0] syn_in;
  logic       pin_b_s;
  logic       wdt_s;
  logic       uv_s;
  rcpoc_cmp_s cmp_s;
  logic       poc_active;

  assign raw_in = {ext_reset_pin_b, watchdog_reset_req, undervoltage_reset_req,
                   supply_above_detect, supply_above_release};

  rcpoc_sync #(.W(5)) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .din     (raw_in),
    .dout    (syn_in)
  );

  assign pin_b_s             = syn_in[4];
  assign wdt_s               = syn_in[3];
  assign uv_s                = syn_in[2];
  assign cmp_s.above_detect  = syn_in[1];
  assign cmp_s.above_release = syn_in[0];

  ////////////////////////////////////////////////////////////////////////////
  // Power-on-clear sequencer

  rcpoc_poc_fsm u_poc (
    .clk_sys          (clk_sys),
    .rst_b            (rst_b),
    .threshold_select (power_on_threshold_select),
    .cmp              (cmp_s),
    .poc_active       (poc_active)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause flags and read port

  logic       wdt_flag_ff;
  logic       uv_flag_ff;
  logic       nxt_wdt_flag;
  logic       nxt_uv_flag;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       rvalid_ff;
  logic       nxt_rvalid;
  logic       chip_rst_b_ff;
  logic       nxt_chip_rst_b;
  logic       rd_hit;
  logic [7:0] cause_view;

  // Byte reads only; single-bit accesses are not answered
  assign rd_hit = bus_rd && bus_byte && (bus_addr == RCPOC_CAUSE_OFFSET);

  always_comb begin
    cause_view                = RCPOC_CAUSE_RESET;
    cause_view[RCPOC_WDT_BIT] = wdt_flag_ff;
    cause_view[RCPOC_UV_BIT]  = uv_flag_ff;
  end

  always_comb begin
    nxt_wdt_flag   = wdt_flag_ff;
    nxt_uv_flag    = uv_flag_ff;
    nxt_rdata      = RCPOC_CAUSE_RESET;
    nxt_rvalid     = 1'b0;
    nxt_chip_rst_b = 1'b0;
    if (!rst_b) begin
      nxt_wdt_flag = 1'b0;
      nxt_uv_flag  = 1'b0;
    end else begin
      if (rd_hit) begin
        nxt_rdata    = cause_view & RCPOC_CAUSE_USED;
        nxt_rvalid   = 1'b1;
        nxt_wdt_flag = 1'b0;
        nxt_uv_flag  = 1'b0;
      end
      // Set wins over the read clear; each source touches only its own flag
      if (wdt_s) nxt_wdt_flag = 1'b1;
      if (uv_s) nxt_uv_flag = 1'b1;
      if (!pin_b_s || poc_active) begin
        nxt_wdt_flag = 1'b0;
        nxt_uv_flag  = 1'b0;
      end
      nxt_chip_rst_b = pin_b_s && !poc_active && !wdt_s && !uv_s;
    end
  end

  always_ff @(posedge clk_sys) begin
    wdt_flag_ff   <= nxt_wdt_flag;
    uv_flag_ff    <= nxt_uv_flag;
    rdata_ff      <= nxt_rdata;
    rvalid_ff     <= nxt_rvalid;
    chip_rst_b_ff <= nxt_chip_rst_b;
  end

  assign bus_rdata    = rdata_ff;
  assign bus_rvalid   = rvalid_ff;
  assign chip_reset_b = chip_rst_b_ff;

endmodule : rcpoc_top

// ===== verif/rcpoc_checker_assertions.sv
// Checker of the reset cause register and reset output
`timescale 1ns/1ps
module rcpoc_checker
  import rcpoc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        ext_reset_pin_b,
  input wire logic        watchdog_reset_req,
  input wire logic        undervoltage_reset_req,
  input wire logic        power_on_threshold_select,
  input wire logic        supply_above_detect,
  input wire logic        supply_above_release,
  input wire logic        bus_rd,
  input wire logic        bus_byte,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_rdata,
  input wire logic        bus_rvalid,
  input wire logic        chip_reset_b
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  logic taken;
  logic ok_ff;
  assign taken = bus_rd && bus_byte && (bus_addr == RCPOC_CAUSE_OFFSET);
  // Pin and supply good since the reset output was last released
  always_ff @(posedge clk_sys) begin
    ok_ff <= rst_b && ext_reset_pin_b && supply_above_detect && (ok_ff || chip_reset_b);
  end
  a_answer_cause: assert property (bus_rvalid |-> $past(taken))
    else $error("answer without byte read");
  a_read_clear: assert property ((!watchdog_reset_req && !undervoltage_reset_req)[*4] ##0 taken ##1 taken |=> bus_rdata == 8'h00)
    else $error("read did not clear");
  a_wdt_sets: assert property ((ok_ff && watchdog_reset_req)[*4] ##1 (ok_ff && !taken)[*7] ##1 taken |=> bus_rdata[RCPOC_WDT_BIT])
    else $error("watchdog flag missing");
  a_uv_sets: assert property ((ok_ff && undervoltage_reset_req)[*4] ##1 (ok_ff && !taken)[*7] ##1 taken |=> bus_rdata[RCPOC_UV_BIT])
    else $error("undervoltage flag missing");
  a_pin_reset: assert property (!ext_reset_pin_b [*6] |-> !chip_reset_b)
    else $error("pin did not reset");
  a_detect_reset: assert property (!supply_above_detect [*6] |-> !chip_reset_b)
    else $error("low supply did not reset");
  a_low_release: assert property ((!power_on_threshold_select && supply_above_detect && ext_reset_pin_b && !watchdog_reset_req && !undervoltage_reset_req)[*8] |-> chip_reset_b)
    else $error("reset not released");
  a_high_hold: assert property (power_on_threshold_select && !supply_above_release && !chip_reset_b |=> !chip_reset_b)
    else $error("released below release level");
endmodule : rcpoc_checker

// ===== verif/rcpoc_far_model.sv
// Far side: watchdog, undervoltage detector, reset pin and supply comparators
`timescale 1ns/1ps
module rcpoc_far_model
  import rcpoc_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic [2:0] fire,
  input wire logic [1:0] supply_lvl,
  output logic           watchdog_reset_req,
  output logic           undervoltage_reset_req,
  output logic           ext_reset_pin_b,
  output rcpoc_cmp_s     cmp
);
  logic [5:0] wd_ff = 6'h00;
  logic [5:0] uv_ff = 6'h00;
  logic [5:0] pin_ff = 6'h00;
  // Each request is held for six cycles so it survives synchronisation
  always @(posedge clk_sys) begin
    wd_ff <= fire[2] ? 6'h3f : wd_ff >> 1;
    uv_ff <= fire[1] ? 6'h3f : uv_ff >> 1;
    pin_ff <= fire[0] ? 6'h3f : pin_ff >> 1;
  end
  assign watchdog_reset_req = wd_ff[0];
  assign undervoltage_reset_req = uv_ff[0];
  assign ext_reset_pin_b = !pin_ff[0];
  // Release level lies above detect level
  assign cmp = {supply_lvl != 2'h0, supply_lvl[1]};
endmodule : rcpoc_far_model

// ===== verif/test_reset_cause_and_power_on_clear.sv
// Testbench of the reset cause and power-on-clear block
`timescale 1ns/1ps
module test_reset_cause_and_power_on_clear
  import rcpoc_pkg::*;
;
  logic        clk_sys = 1'b0, rst_b = 1'b0, power_on_threshold_select = 1'b1, bus_rd = 1'b0, bus_byte = 1'b0, b;
  logic [15:0] bus_addr = 16'h0000, a;
  logic [2:0]  fire = 3'h0;
  logic [1:0]  supply_lvl = 2'h1;
  logic [7:0]  bus_rdata, exp_flags = 8'h00;
  logic [31:0] k;
  logic        bus_rvalid, chip_reset_b, watchdog_reset_req, undervoltage_reset_req, ext_reset_pin_b;
  rcpoc_cmp_s  cmp;
  int          bad_count = 0, total_checks = 0;

  always #4 clk_sys = ~clk_sys;

  rcpoc_far_model u_far (.clk_sys, .fire, .supply_lvl, .watchdog_reset_req, .undervoltage_reset_req,
                         .ext_reset_pin_b, .cmp);
  rcpoc_top DUT (.clk_sys, .rst_b, .ext_reset_pin_b, .watchdog_reset_req, .undervoltage_reset_req,
                 .power_on_threshold_select, .supply_above_detect(cmp.above_detect),
                 .supply_above_release(cmp.above_release), .bus_rd, .bus_byte, .bus_addr, .bus_rdata,
                 .bus_rvalid, .chip_reset_b);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] flags_after(input logic [7:0] old, input logic w, input logic u, input logic clr);
    flags_after = clr ? 8'h00 : old | {3'h0, w, 3'h0, u};
  endfunction : flags_after

  task automatic chk(input logic [8:0] got, input logic [8:0] want);
    total_checks++;
    if (got !== want) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, want);
    end
  endtask : chk

  task automatic print_verdict;
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // Byte or refused read, n back to back; only the first may return flags
  task automatic rd(input logic [15:0] ra, input logic rb, input int n, input logic [7:0] e);
    bus_addr <= ra;
    bus_byte <= rb;
    bus_rd <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      if (i == n - 1) bus_rd <= 1'b0;
      #1;
      chk({bus_rvalid, bus_rdata}, (rb && ra == RCPOC_CAUSE_OFFSET) ? {1'b1, (i == 0) ? e : 8'h00} : 9'h000);
    end
  endtask : rd

  task automatic wait_rel;
    for (int i = 0; i < 300 && chip_reset_b !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (chip_reset_b !== 1'b1) begin
      bad_count++;
      print_verdict;
    end
  endtask : wait_rel

  task automatic pulse(input logic [2:0] v);
    @(posedge clk_sys);
    fire <= v;
    @(posedge clk_sys);
    fire <= 3'h0;
    repeat (12) @(posedge clk_sys);
  endtask : pulse

  initial begin
    k = $urandom(30);
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (40) @(posedge clk_sys);
    #1;
    chk({8'h00, chip_reset_b}, 9'h000);
    rd(RCPOC_CAUSE_OFFSET, 1'b1, 1, RCPOC_CAUSE_RESET);
    rst_b <= 1'b0;
    power_on_threshold_select <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    wait_rel;
    for (int it = 0; it < 40; it++) begin
      k = $urandom;
      pulse({k[0], k[1], k[4]});
      if (k[5]) begin
        supply_lvl <= 2'h0;
        repeat (10) @(posedge clk_sys);
        #1;
        chk({8'h00, chip_reset_b}, 9'h000);
        supply_lvl <= 2'h1 + k[7];
        wait_rel;
      end
      exp_flags = flags_after(exp_flags, k[0], k[1], k[4] | k[5]);
      a = (k[2] && !k[3]) ? k[31:16] : RCPOC_CAUSE_OFFSET;
      b = !(k[2] && k[3]);
      rd(a, b, 1 + k[6], exp_flags);
      if (b && a == RCPOC_CAUSE_OFFSET) exp_flags = 8'h00;
    end
    print_verdict;
  end
endmodule : test_reset_cause_and_power_on_clear

bind rcpoc_top rcpoc_checker u_chk (.clk_sys, .rst_b, .ext_reset_pin_b, .watchdog_reset_req,
  .undervoltage_reset_req, .power_on_threshold_select, .supply_above_detect, .supply_above_release,
  .bus_rd, .bus_byte, .bus_addr, .bus_rdata, .bus_rvalid, .chip_reset_b);
